// File: rtl/sag_defs.svh
// constants for the segment address generator: codes, field positions, reset values, reserved ports
`ifndef SAG_DEFS_SVH
`define SAG_DEFS_SVH

// segment register codes
`define SAG_SEG_EXTRA 3'h0
`define SAG_SEG_CODE 3'h1
`define SAG_SEG_STACK 3'h2
`define SAG_SEG_DATA 3'h3
`define SAG_SEG_SECOND 3'h4
`define SAG_SEG_THIRD 3'h5
`define SAG_SEG_COUNT 6

// general register codes used as a base
`define SAG_REG_STACK_TOP 3'h4
`define SAG_REG_FRAME_BASE 3'h5

// operand size codes
`define SAG_SIZE_BYTE 2'h0
`define SAG_SIZE_WORD 2'h1
`define SAG_SIZE_DWORD 2'h2

// address field layout
`define SAG_REAL_SHIFT 4
`define SAG_PAGE_BITS 12
`define SAG_REAL_LIMIT 32'h0000_FFFF
`define SAG_IO_TOP 17'h0_FFFF

// reset values
`define SAG_ADDR_RST 32'h0000_0000
`define SAG_DATA_RST 32'h0000_0000
`define SAG_BYTE_RST 8'h00
`define SAG_CNT_RST 2'h0

// port range kept free of peripherals by the system
`define SAG_IO_RSVD_LO 16'h00F8
`define SAG_IO_RSVD_HI 16'h00FF

`endif

// File: rtl/sag_pkg.sv
// types shared by the segment address generator
package sag_pkg;

	// kind of reference presented with a request
	typedef enum logic [2:0] {
		SAG_REF_CODE = 3'h0,
		SAG_REF_STACK = 3'h1,
		SAG_REF_DATA = 3'h2,
		SAG_REF_STR_DST = 3'h3,
		SAG_REF_IO = 3'h4
	} sag_ref_e;

	// outcome reported with each completion
	typedef enum logic [2:0] {
		SAG_FLT_NONE = 3'h0,
		SAG_FLT_LIMIT = 3'h1,
		SAG_FLT_PAGE_MISS = 3'h2,
		SAG_FLT_PAGE_CROSS = 3'h3,
		SAG_FLT_IO_RANGE = 3'h4
	} sag_fault_e;

	// transfer sequencer, one-hot
	typedef enum logic [2:0] {
		SAG_ST_IDLE = 3'b001,
		SAG_ST_XFER = 3'b010,
		SAG_ST_DONE = 3'b100
	} sag_state_e;

	typedef logic [2:0] sag_seg_t;

endpackage

// File: rtl/sag_top.sv
// segment address generator: effective, linear and physical address plus byte bus
`timescale 1ns/1ps
`include "sag_defs.svh"

module sag_top #(
	parameter int PG_ENTRIES = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// request from the core
	input wire logic req_valid,
	output logic req_ready,
	input wire sag_pkg::sag_ref_e req_ref,
	input wire logic req_write,
	input wire logic [1:0] req_size,
	input wire logic [31:0] req_wdata,
	// operand address components
	input wire logic base_en,
	input wire logic [2:0] base_id,
	input wire logic [31:0] base_val,
	input wire logic index_en,
	input wire logic [31:0] index_val,
	input wire logic [1:0] index_scale,
	input wire logic [31:0] disp_val,
	input wire logic ovr_en,
	input wire sag_pkg::sag_seg_t ovr_seg,
	// port address sources
	input wire logic io_use_imm,
	input wire logic [7:0] io_imm,
	input wire logic [15:0] port_address_register,
	// mode and segment state
	input wire logic prot_mode,
	input wire logic paging_on,
	input wire logic [15:0] seg_sel [`SAG_SEG_COUNT],
	input wire logic [31:0] seg_base [`SAG_SEG_COUNT],
	input wire logic [31:0] seg_limit [`SAG_SEG_COUNT],
	// page map fill
	input wire logic pg_fill_en,
	input wire logic [19:0] pg_fill_page,
	input wire logic [19:0] pg_fill_frame,
	// byte bus toward memory and peripherals
	output logic bus_valid,
	output logic bus_write,
	output logic mem_io_sel,
	output logic [31:0] bus_addr,
	output logic [7:0] bus_byte,
	input wire logic [7:0] bus_rd_byte,
	// completion
	output logic done,
	output sag_pkg::sag_fault_e done_fault,
	output logic [31:0] done_rdata
);

	localparam int IDX_W = $clog2(PG_ENTRIES);
	localparam int TAG_W = 20 - IDX_W;

	// the page map is direct indexed, so it needs a power of two entries
	if (PG_ENTRIES < 2 || (1 << IDX_W) != PG_ENTRIES) begin
		$error("PG_ENTRIES must be a power of two of at least 2");
	end

	// default segment choice with override handling
	function automatic sag_pkg::sag_seg_t pick_seg(input sag_pkg::sag_ref_e rf,
			input logic [2:0] bid, input logic oe, input sag_pkg::sag_seg_t os);
		sag_pkg::sag_seg_t s;
		s = `SAG_SEG_DATA;
		unique case (rf)
			sag_pkg::SAG_REF_CODE: s = `SAG_SEG_CODE;
			sag_pkg::SAG_REF_STACK: s = `SAG_SEG_STACK;
			sag_pkg::SAG_REF_STR_DST: s = `SAG_SEG_EXTRA;
			sag_pkg::SAG_REF_DATA: begin
				if (bid == `SAG_REG_FRAME_BASE || bid == `SAG_REG_STACK_TOP) begin
					s = `SAG_SEG_STACK;
				end else begin
					s = `SAG_SEG_DATA;
				end
				// codes above the six registers are ignored
				if (oe && os <= `SAG_SEG_THIRD) begin
					s = os;
				end
			end
			default: s = `SAG_SEG_DATA;
		endcase
		return s;
	endfunction

	sag_pkg::sag_state_e state_q;
	sag_pkg::sag_fault_e fault_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic [1:0] cnt_q;
	logic [1:0] last_q;
	logic [31:0] addr_q;
	logic [7:0] byte_q;
	logic valid_q;
	logic write_q;
	logic mio_q;
	logic pg_valid_q [PG_ENTRIES];
	logic [TAG_W-1:0] pg_tag_q [PG_ENTRIES];
	logic [19:0] pg_frame_q [PG_ENTRIES];

	logic accept;
	logic is_io;
	sag_pkg::sag_seg_t seg;
	logic [31:0] ea;
	logic [31:0] linear;
	logic [31:0] phys;
	logic [31:0] limit;
	logic [1:0] span;
	logic [32:0] end_off;
	logic [15:0] port;
	logic [16:0] port_end;
	logic [31:0] lin_last;
	logic [19:0] vpage;
	logic pg_hit;
	sag_pkg::sag_fault_e fault_now;

	assign req_ready = (state_q == sag_pkg::SAG_ST_IDLE);
	assign accept = req_valid && req_ready;
	assign is_io = (req_ref == sag_pkg::SAG_REF_IO);
	assign done = (state_q == sag_pkg::SAG_ST_DONE);

	// effective address and segment pick; overlapping bases need no check
	always_comb begin
		seg = pick_seg(req_ref, base_id, ovr_en, ovr_seg);
		ea = (base_en ? base_val : 32'h0000_0000)
			+ ((index_en ? index_val : 32'h0000_0000) << index_scale)
			+ disp_val;
		span = (req_size == `SAG_SIZE_DWORD) ? 2'h3 :
			(req_size == `SAG_SIZE_WORD) ? 2'h1 : 2'h0;
	end

	// logical to linear: real shifts the selector, protected adds the base
	always_comb begin
		if (prot_mode) begin
			linear = seg_base[seg] + ea;
			limit = seg_limit[seg];
		end else begin
			linear = {12'h000, seg_sel[seg], 4'h0} + ea;
			limit = `SAG_REAL_LIMIT;
		end
		// limit is size minus one, so 0 is one byte and all ones is 4 GB
		end_off = {1'b0, ea} + {31'h0000_0000, span};
		lin_last = linear + {30'h0000_0000, span};
	end

	// page lookup on 4K pages; page offset bits pass through
	always_comb begin
		vpage = linear[31:`SAG_PAGE_BITS];
		pg_hit = pg_valid_q[vpage[IDX_W-1:0]] && (pg_tag_q[vpage[IDX_W-1:0]] == vpage[19:IDX_W]);
		if (paging_on) begin
			phys = {pg_frame_q[vpage[IDX_W-1:0]], linear[`SAG_PAGE_BITS-1:0]};
		end else begin
			phys = linear;
		end
	end

	// port address, zero extended, never translated
	always_comb begin
		port = io_use_imm ? {8'h00, io_imm} : port_address_register;
		port_end = {1'b0, port} + {15'h0000, span};
	end

	// fault priority: io range, limit, page crossing, page miss
	always_comb begin
		fault_now = sag_pkg::SAG_FLT_NONE;
		if (is_io) begin
			if (port_end > `SAG_IO_TOP) begin
				fault_now = sag_pkg::SAG_FLT_IO_RANGE;
			end
		end else if (end_off > {1'b0, limit}) begin
			fault_now = sag_pkg::SAG_FLT_LIMIT;
		end else if (paging_on) begin
			// one lookup per request, so an operand may not straddle two pages
			if (lin_last[31:`SAG_PAGE_BITS] != vpage) begin
				fault_now = sag_pkg::SAG_FLT_PAGE_CROSS;
			end else if (!pg_hit) begin
				fault_now = sag_pkg::SAG_FLT_PAGE_MISS;
			end
		end
	end

	// page map fill from the core's walker
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < PG_ENTRIES; i++) begin
			if (rst) begin
				pg_valid_q[i] <= 1'b0;
				pg_tag_q[i] <= '0;
				pg_frame_q[i] <= 20'h0_0000;
			end else if (pg_fill_en && pg_fill_page[IDX_W-1:0] == IDX_W'(i)) begin
				pg_valid_q[i] <= 1'b1;
				pg_tag_q[i] <= pg_fill_page[19:IDX_W];
				pg_frame_q[i] <= pg_fill_frame;
			end
		end
	end

	// sequencer: idle, one byte a cycle, one completion cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= sag_pkg::SAG_ST_IDLE;
			fault_q <= sag_pkg::SAG_FLT_NONE;
			cnt_q <= `SAG_CNT_RST;
			last_q <= `SAG_CNT_RST;
		end else begin
			unique case (state_q)
				sag_pkg::SAG_ST_IDLE: begin
					if (accept) begin
						fault_q <= fault_now;
						cnt_q <= `SAG_CNT_RST;
						last_q <= span;
						state_q <= (fault_now == sag_pkg::SAG_FLT_NONE) ?
							sag_pkg::SAG_ST_XFER : sag_pkg::SAG_ST_DONE;
					end
				end
				sag_pkg::SAG_ST_XFER: begin
					if (cnt_q == last_q) begin
						state_q <= sag_pkg::SAG_ST_DONE;
					end else begin
						cnt_q <= cnt_q + 2'h1;
					end
				end
				sag_pkg::SAG_ST_DONE: begin
					state_q <= sag_pkg::SAG_ST_IDLE;
				end
			endcase
		end
	end

	// bus address: start at the low byte, step upward
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_q <= `SAG_ADDR_RST;
			valid_q <= 1'b0;
			write_q <= 1'b0;
			mio_q <= 1'b1;
		end else if (accept && fault_now == sag_pkg::SAG_FLT_NONE) begin
			addr_q <= is_io ? {16'h0000, port} : phys;
			valid_q <= 1'b1;
			write_q <= req_write;
			mio_q <= !is_io;
		end else if (state_q == sag_pkg::SAG_ST_XFER) begin
			if (cnt_q == last_q) begin
				valid_q <= 1'b0;
				mio_q <= 1'b1;
			end else begin
				addr_q <= addr_q + 32'h0000_0001;
			end
		end
	end

	// write bytes leave least significant first
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wdata_q <= `SAG_DATA_RST;
			byte_q <= `SAG_BYTE_RST;
		end else if (accept) begin
			wdata_q <= req_wdata;
			byte_q <= req_wdata[7:0];
		end else if (state_q == sag_pkg::SAG_ST_XFER && cnt_q != last_q) begin
			byte_q <= wdata_q[8 * (32'(cnt_q) + 1) +: 8];
		end
	end

	// read bytes gather into place by lane; the bus answers in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= `SAG_DATA_RST;
		end else if (accept) begin
			rdata_q <= `SAG_DATA_RST;
		end else if (valid_q && !write_q) begin
			rdata_q[8 * 32'(cnt_q) +: 8] <= bus_rd_byte;
		end
	end

	assign bus_valid = valid_q;
	assign bus_write = write_q;
	assign mem_io_sel = mio_q;
	assign bus_addr = addr_q;
	assign bus_byte = byte_q;
	assign done_fault = fault_q;
	assign done_rdata = rdata_q;

	// checks on segment choice
	a_code_seg_fixed: assert property (@(posedge ref_clk) disable iff (rst)
		accept && req_ref == sag_pkg::SAG_REF_CODE |-> seg == `SAG_SEG_CODE)
		else $error("code fetch not on code segment");

	a_stack_seg_fixed: assert property (@(posedge ref_clk) disable iff (rst)
		accept && req_ref == sag_pkg::SAG_REF_STACK |-> seg == `SAG_SEG_STACK)
		else $error("push or pop not on stack segment");

	a_str_dst_extra: assert property (@(posedge ref_clk) disable iff (rst)
		accept && req_ref == sag_pkg::SAG_REF_STR_DST && !is_io
		|-> seg == `SAG_SEG_EXTRA)
		else $error("string destination not on extra segment");

	a_frame_default_stack: assert property (@(posedge ref_clk) disable iff (rst)
		accept && req_ref == sag_pkg::SAG_REF_DATA && !ovr_en
		&& base_id == `SAG_REG_FRAME_BASE |-> seg == `SAG_SEG_STACK)
		else $error("frame based data not on stack segment");

	a_override_taken: assert property (@(posedge ref_clk) disable iff (rst)
		accept && req_ref == sag_pkg::SAG_REF_DATA && ovr_en
		&& ovr_seg == `SAG_SEG_SECOND |-> seg == `SAG_SEG_SECOND)
		else $error("override prefix ignored");

	// checks on the produced addresses, byte order and byte count
	a_real_linear_addr: assert property (@(posedge ref_clk) disable iff (rst)
		accept && !is_io && !prot_mode && !paging_on
		&& fault_now == sag_pkg::SAG_FLT_NONE
		|=> bus_addr == $past(seg_sel[seg]) * 32'h0000_0010 + $past(ea))
		else $error("real mode address wrong");

	a_paging_off_pass: assert property (@(posedge ref_clk) disable iff (rst)
		accept && !is_io && prot_mode && !paging_on
		&& fault_now == sag_pkg::SAG_FLT_NONE
		|=> bus_addr == $past(seg_base[seg]) + $past(ea) && mem_io_sel)
		else $error("linear address not passed through");

	a_page_offset_kept: assert property (@(posedge ref_clk) disable iff (rst)
		accept && !is_io && paging_on && fault_now == sag_pkg::SAG_FLT_NONE
		|=> bus_addr[11:0] == $past(linear[11:0]))
		else $error("page offset altered");

	a_io_port_low: assert property (@(posedge ref_clk) disable iff (rst)
		accept && is_io && fault_now == sag_pkg::SAG_FLT_NONE
		|=> !mem_io_sel && bus_valid && bus_addr[31:16] == 16'h0000)
		else $error("io access not marked or not zero extended");

	a_word_byte_order: assert property (@(posedge ref_clk) disable iff (rst)
		accept && req_write && req_size == `SAG_SIZE_WORD
		&& fault_now == sag_pkg::SAG_FLT_NONE
		|=> bus_byte == $past(req_wdata[7:0])
		##1 bus_byte == $past(req_wdata[15:8], 2) && bus_addr == $past(bus_addr) + 32'h1)
		else $error("word bytes out of order");

	a_dword_span: assert property (@(posedge ref_clk) disable iff (rst)
		accept && req_size == `SAG_SIZE_DWORD && fault_now == sag_pkg::SAG_FLT_NONE
		|=> bus_valid [*4] ##1 !bus_valid && done)
		else $error("dword not four bytes");

endmodule

// File: sim/sag_bus_model.sv
// behavioural memory and peripheral bus on the far side of the address generator
`timescale 1ns/1ps

module sag_bus_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic log_clr,
	// byte bus from the generator
	input wire logic bus_valid,
	input wire logic bus_write,
	input wire logic mem_io_sel,
	input wire logic [31:0] bus_addr,
	input wire logic [7:0] bus_byte,
	output logic [7:0] bus_rd_byte
);
	logic [31:0] n;
	logic [31:0] lg_addr [4];
	logic [7:0] lg_byte [4];
	logic lg_io [4];
	logic lg_wr [4];
	logic [7:0] last_q;
	logic [31:0] rsvd_hits;

	// read data is a fixed pattern of the address; released bus shows the inverse of the last byte
	always_comb begin
		if (bus_valid) begin
			bus_rd_byte = bus_addr[7:0] ^ (mem_io_sel ? 8'hA5 : 8'h3C);
		end else begin
			bus_rd_byte = ~last_q;
		end
	end

	// log each byte cycle; only the first four are kept, the count goes on
	always_ff @(posedge ref_clk) begin
		if (rst || log_clr) begin
			n <= 32'h0000_0000;
		end else if (bus_valid) begin
			if (n < 4) begin
				lg_addr[n[1:0]] <= bus_addr;
				lg_byte[n[1:0]] <= bus_byte;
				lg_io[n[1:0]] <= mem_io_sel;
				lg_wr[n[1:0]] <= bus_write;
			end
			n <= n + 32'h0000_0001;
		end
	end

	// no peripheral sits in the reserved port range, so such hits are only counted
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rsvd_hits <= 32'h0000_0000;
			last_q <= 8'h00;
		end else if (bus_valid) begin
			last_q <= bus_rd_byte;
			if (!mem_io_sel && bus_addr >= 32'h0000_00F8 && bus_addr <= 32'h0000_00FF) begin
				rsvd_hits <= rsvd_hits + 32'h0000_0001;
			end
		end
	end
endmodule

// File: sim/sag_top_tb_top.sv
// self-checking bench for the segment address generator
`timescale 1ns/1ps
`include "sag_defs.svh"

module sag_top_tb_top;
	logic ref_clk = 0, rst = 1, req_valid = 0, req_write = 0, base_en = 0, index_en = 0;
	logic ovr_en = 0, io_use_imm = 0, prot_mode = 0, paging_on = 0, pg_fill_en = 0, log_clr = 0;
	sag_pkg::sag_ref_e req_ref = sag_pkg::SAG_REF_DATA;
	sag_pkg::sag_seg_t ovr_seg = 3'h0;
	logic [1:0] req_size = 2'h0, index_scale = 2'h0;
	logic [2:0] base_id = 3'h0;
	logic [31:0] req_wdata = 32'h0000_0000, base_val = 32'h0000_0000;
	logic [31:0] index_val = 32'h0000_0000, disp_val = 32'h0000_0000;
	logic [7:0] io_imm = 8'h00;
	logic [15:0] port_address_register = 16'h0000;
	logic [15:0] seg_sel [`SAG_SEG_COUNT];
	logic [31:0] seg_base [`SAG_SEG_COUNT];
	logic [31:0] seg_limit [`SAG_SEG_COUNT];
	logic [19:0] pg_fill_page = 20'h0_0000, pg_fill_frame = 20'h0_0000;
	logic req_ready, bus_valid, bus_write, mem_io_sel, done;
	logic [31:0] bus_addr, done_rdata;
	logic [7:0] bus_byte, bus_rd_byte;
	sag_pkg::sag_fault_e done_fault;
	int miscompares = 0, checked = 0;

	// free-running clock, 100 ns period
	always #50 ref_clk = ~ref_clk;

	sag_top sag_top_i (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_ref(req_ref), .req_write(req_write),
		.req_size(req_size), .req_wdata(req_wdata), .base_en(base_en), .base_id(base_id),
		.base_val(base_val), .index_en(index_en), .index_val(index_val),
		.index_scale(index_scale), .disp_val(disp_val), .ovr_en(ovr_en), .ovr_seg(ovr_seg),
		.io_use_imm(io_use_imm), .io_imm(io_imm),
		.port_address_register(port_address_register), .prot_mode(prot_mode),
		.paging_on(paging_on), .seg_sel(seg_sel), .seg_base(seg_base),
		.seg_limit(seg_limit), .pg_fill_en(pg_fill_en), .pg_fill_page(pg_fill_page),
		.pg_fill_frame(pg_fill_frame), .bus_valid(bus_valid), .bus_write(bus_write),
		.mem_io_sel(mem_io_sel), .bus_addr(bus_addr), .bus_byte(bus_byte),
		.bus_rd_byte(bus_rd_byte), .done(done), .done_fault(done_fault),
		.done_rdata(done_rdata));

	sag_bus_model sag_bus_model_i (.ref_clk(ref_clk), .rst(rst), .log_clr(log_clr),
		.bus_valid(bus_valid), .bus_write(bus_write), .mem_io_sel(mem_io_sel),
		.bus_addr(bus_addr), .bus_byte(bus_byte), .bus_rd_byte(bus_rd_byte));

	task automatic conclude();
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// linear address the bench expects for a segment and offset
	function automatic logic [31:0] lin(input int s, input logic [31:0] ea);
		return prot_mode ? seg_base[s] + ea : {12'h000, seg_sel[s], 4'h0} + ea;
	endfunction

	task automatic comp(input logic bid_en, input logic [2:0] bid, input logic [31:0] bv,
		input logic [31:0] iv, input logic [1:0] sc, input logic [31:0] dv);
		base_en = bid_en;
		base_id = bid;
		base_val = bv;
		index_en = (iv != 0);
		index_val = iv;
		index_scale = sc;
		disp_val = dv;
	endtask

	// one request: hold until taken, wait for done, then compare bytes and result
	task automatic run(input sag_pkg::sag_ref_e r, input logic w, input logic [1:0] sz,
		input logic [31:0] a, input logic io, input int nb, input sag_pkg::sag_fault_e f);
		int i;
		logic [31:0] rd;
		logic [31:0] ak;
		rd = 32'h0000_0000;
		req_ref = r;
		req_write = w;
		req_size = sz;
		req_wdata = 32'h8899_AABB;
		log_clr = 1;
		req_valid = 1;
		for (i = 0; i < 20 && req_ready !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 20) begin
			miscompares++;
			conclude();
		end
		@(posedge ref_clk);
		#1;
		req_valid = 0;
		log_clr = 0;
		for (i = 0; i < 20 && done !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 20) begin
			miscompares++;
			conclude();
		end
		check("fault", {29'h0, done_fault}, {29'h0, f});
		check("byte count", sag_bus_model_i.n, 32'(nb));
		for (int k = 0; k < nb; k++) begin
			ak = a + 32'(k);
			check("address", sag_bus_model_i.lg_addr[k], ak);
			check("space", {31'h0, sag_bus_model_i.lg_io[k]}, {31'h0, io});
			check("direction", {31'h0, sag_bus_model_i.lg_wr[k]}, {31'h0, w});
			if (w) check("write byte", {24'h0, sag_bus_model_i.lg_byte[k]}, {24'h0, req_wdata[8*k +: 8]});
			rd[8*k +: 8] = ak[7:0] ^ (io ? 8'hA5 : 8'h3C);
		end
		if (!w && f == sag_pkg::SAG_FLT_NONE) check("read data", done_rdata, rd);
		@(posedge ref_clk);
		#1;
	endtask

	task automatic t_real();
		comp(1, 3'h0, 32'h0000_0100, 32'h0000_0010, 2'h2, 32'h0000_0004);
		run(sag_pkg::SAG_REF_DATA, 1, 2'h2, lin(3, 32'h144), 1, 4,
			sag_pkg::SAG_FLT_NONE);
		comp(1, `SAG_REG_FRAME_BASE, 32'h0000_0200, 32'h0, 2'h0, 32'h0000_0002);
		run(sag_pkg::SAG_REF_DATA, 0, 2'h1, lin(2, 32'h202), 1, 2,
			sag_pkg::SAG_FLT_NONE);
		comp(1, `SAG_REG_STACK_TOP, 32'h0000_0300, 32'h0, 2'h0, 32'h0);
		run(sag_pkg::SAG_REF_DATA, 1, 2'h1, lin(2, 32'h300), 1, 2, sag_pkg::SAG_FLT_NONE);
		// real mode offsets stop at 64K, so a word at the top edge must fault
		comp(0, 3'h0, 32'h0, 32'h0, 2'h0, 32'h0000_FFFF);
		run(sag_pkg::SAG_REF_DATA, 0, 2'h1, 32'h0, 1, 0, sag_pkg::SAG_FLT_LIMIT);
	endtask

	task automatic t_seg();
		comp(1, 3'h1, 32'h0000_0040, 32'h0, 2'h0, 32'h0);
		ovr_en = 1;
		for (int s = 0; s < `SAG_SEG_COUNT; s++) begin
			ovr_seg = 3'(s);
			run(sag_pkg::SAG_REF_DATA, 0, 2'h0, lin(s, 32'h40), 1, 1, sag_pkg::SAG_FLT_NONE);
		end
		ovr_seg = `SAG_SEG_DATA;
		run(sag_pkg::SAG_REF_CODE, 0, 2'h2, lin(1, 32'h40), 1, 4, sag_pkg::SAG_FLT_NONE);
		run(sag_pkg::SAG_REF_STACK, 1, 2'h2, lin(2, 32'h40), 1, 4, sag_pkg::SAG_FLT_NONE);
		run(sag_pkg::SAG_REF_STR_DST, 1, 2'h1, lin(0, 32'h40), 1, 2, sag_pkg::SAG_FLT_NONE);
		ovr_en = 0;
	endtask

	task automatic t_prot();
		prot_mode = 1;
		comp(0, 3'h0, 32'h0, 32'h0000_0100, 2'h3, 32'h0000_0010);
		run(sag_pkg::SAG_REF_DATA, 0, 2'h2, 32'h0000_0810, 1, 4,
			sag_pkg::SAG_FLT_NONE);
		seg_base[3] = 32'h00AB_0000;
		seg_limit[3] = 32'h0000_0FFF;
		comp(0, 3'h0, 32'h0, 32'h0, 2'h0, 32'h0000_0FFE);
		run(sag_pkg::SAG_REF_DATA, 1, 2'h1, 32'h00AB_0FFE, 1, 2, sag_pkg::SAG_FLT_NONE);
		disp_val = 32'h0000_0FFF;
		run(sag_pkg::SAG_REF_DATA, 1, 2'h1, 32'h0, 1, 0, sag_pkg::SAG_FLT_LIMIT);
		seg_base[3] = 32'h0000_0000;
		seg_limit[3] = 32'hFFFF_FFFF;
	endtask

	task automatic t_page();
		@(posedge ref_clk);
		#1;
		pg_fill_en = 1;
		pg_fill_page = 20'h0_0012;
		pg_fill_frame = 20'hA_BCDE;
		@(posedge ref_clk);
		#1;
		pg_fill_en = 0;
		paging_on = 1;
		comp(0, 3'h0, 32'h0, 32'h0, 2'h0, 32'h0001_2345);
		run(sag_pkg::SAG_REF_DATA, 0, 2'h1, 32'hABCD_E345, 1, 2, sag_pkg::SAG_FLT_NONE);
		disp_val = 32'h0001_3000;
		run(sag_pkg::SAG_REF_DATA, 0, 2'h0, 32'h0, 1, 0, sag_pkg::SAG_FLT_PAGE_MISS);
		disp_val = 32'h0001_2FFE;
		run(sag_pkg::SAG_REF_DATA, 0, 2'h2, 32'h0, 1, 0, sag_pkg::SAG_FLT_PAGE_CROSS);
	endtask

	task automatic t_io();
		ovr_en = 1;
		ovr_seg = `SAG_SEG_THIRD;
		port_address_register = 16'h1234;
		run(sag_pkg::SAG_REF_IO, 1, 2'h2, 32'h0000_1234, 0, 4,
			sag_pkg::SAG_FLT_NONE);
		io_use_imm = 1;
		io_imm = 8'h80;
		run(sag_pkg::SAG_REF_IO, 0, 2'h0, 32'h0000_0080, 0, 1, sag_pkg::SAG_FLT_NONE);
		io_use_imm = 0;
		port_address_register = 16'hFFFC;
		run(sag_pkg::SAG_REF_IO, 0, 2'h2, 32'h0000_FFFC, 0, 4, sag_pkg::SAG_FLT_NONE);
		port_address_register = 16'hFFFE;
		run(sag_pkg::SAG_REF_IO, 1, 2'h2, 32'h0, 0, 0, sag_pkg::SAG_FLT_IO_RANGE);
		check("reserved ports", sag_bus_model_i.rsvd_hits, 32'h0);
		ovr_en = 0;
	endtask

	initial begin
		for (int s = 0; s < `SAG_SEG_COUNT; s++) begin
			seg_sel[s] = 16'h1000 * 16'(s + 1);
			seg_base[s] = 32'h0000_0000;
			seg_limit[s] = 32'hFFFF_FFFF;
		end
		repeat (5) @(posedge ref_clk);
		#1;
		rst = 0;
		check("idle ready", {31'h0, req_ready}, 32'h1);
		check("idle space", {31'h0, mem_io_sel}, 32'h1);
		check("idle bus", {31'h0, bus_valid}, 32'h0);
		t_real();
		t_seg();
		t_prot();
		t_page();
		t_io();
		conclude();
	end
endmodule
